// ### src/radio_spi_command_irq.sv
// serial command interpreter and interrupt pin logic of the radio control port
`timescale 1ns/100ps

// Notes on behaviour
// [R1] irq pin goes low while any unmasked done, ready or retry flag is set
// [R2] writing one to a status flag bit clears it; pin releases when none remain
// [R3] three mask bits block their sources; all clear after reset
// [R4] pipe field of status is updated when the irq pin falls
// [R5] host starts each command with a fresh falling edge of chip select
// [R6] status byte is shifted out while the command byte is shifted in
// [R7] command msb first; data lsb byte first except reversed bank one registers
// [R8] bank one registers 0 to 8 move most significant byte first
// [R9] register read command returns one to five bytes of the addressed register
// [R10] register write takes one to five bytes, only in power down or standby
// [R11] payload read returns up to 32 bytes from byte 0, then drops the payload
// [R12] payload write takes up to 32 bytes starting at byte 0
// [R13] transmit flush command empties the transmit fifo, no data bytes
// [R14] receive flush command empties the receive fifo, no data bytes
// [R15] repeat command resends last payload until a payload write or flush
// [R16] activate plus 0x73 toggles the three optional commands, standby only; the code also accepts it in power down
// [R17] optional commands start disabled; then writes do nothing, reads give zeros
// [R18] activate plus 0x53 toggles the bank; bank shows at status bit 7
// [R19] width read returns the width of the receive fifo head entry
// [R20] ack payload write for pipes 0 to 5 in receive mode
// [R21] unacked payload write in transmit mode marks the packet for no ack
// [R22] no operation command only returns the status byte
// [R23] data sampled on rising link clock, driven on falling, released when deselected
// [R24] receive ready mask bit 6, transmit done bit 5, retry limit bit 4
module radio_spi_command_irq #(
  parameter int PAYLOAD_BYTES = radio_spi_pkg::MAX_PAYLOAD_BYTES // payload length limit
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic sck, // link clock from the host
  input wire logic chipSelectN, // frame select, active low
  input wire logic mosi, // serial data from the host
  output logic misoOut, // serial data to the host
  output logic misoEn, // high while the data pin is driven
  output logic irqN, // interrupt pin, active low
  input wire logic transmitDoneSet, // pulse: packet sent
  input wire logic receiveReadySet, // pulse: packet received
  input wire logic retryLimitSet, // pulse: retries exhausted
  input wire logic [2:0] pipeNumberIn, // pipe of the received packet
  input wire logic txFifoFull, // transmit fifo full level
  input wire logic writeAllowed, // high in power down or standby
  input wire logic receiveMode, // high when primary receiver
  output logic [4:0] regAddr, // addressed register
  output logic regBank, // selected register bank
  output logic [2:0] regLane, // byte lane of the current data byte
  input wire logic [2:0] regByteCount, // width in bytes of the addressed register
  input wire logic [7:0] regRdData, // byte at regAddr and regLane
  output logic regWrStrobe, // pulse: write regWrData to regLane
  output logic [7:0] regWrData, // register write byte
  output logic [4:0] rxByteIndex, // byte index of the payload read
  input wire logic [7:0] rxData, // payload byte at rxByteIndex
  input wire logic [5:0] rxHeadWidth, // width of the receive fifo head entry
  output logic rxPayloadDone, // pulse: drop the head payload
  output logic txPushStrobe, // pulse: store txPushData at txByteIndex
  output logic [7:0] txPushData, // payload byte
  output logic [4:0] txByteIndex, // payload byte index
  output logic txNoAck, // current payload asks for no ack
  output logic txAckPayload, // current payload is an ack payload
  output logic [2:0] txAckPipe, // pipe of the ack payload
  output logic txPayloadDone, // pulse: payload write ended
  output logic flushTx, // pulse: empty transmit fifo
  output logic flushRx, // pulse: empty receive fifo
  output logic payloadRepeat, // level: resend last payload
  output logic featuresActive, // level: optional commands enabled
  output logic [2:0] interruptMask // level: ready, done, retry masks
);

  typedef enum {ST_CMD, ST_REG_RD, ST_REG_WR, ST_RX_RD, ST_TX_WR, ST_WIDTH,
                ST_ACTIVATE, ST_IGNORE} cmd_state_t;

  cmd_state_t state;
  cmd_state_t cmdState;
  logic csMeta, csSync, csPrev, frameActive, frameStart, frameEnd;
  logic tglMeta, tglSync, tglSeen, byteEvent, cmdEvent, dataEvent;
  logic linkClear, cmdTaken, dataTaken, loadTx;
  logic [7:0] rxByte, txWord, statusWord, statusNow;
  logic byteToggle, reversed;
  logic [5:0] cnt;
  logic [2:0] flags, next_flags, clearMask, pipeField, next_mask;
  logic next_irqN;

  initial begin
    if (PAYLOAD_BYTES < 1 || PAYLOAD_BYTES > 32) begin
      $error("PAYLOAD_BYTES must lie in 1..32");
    end
  end

  // ==========================================================
  // link side shifter
  spi_link_shifter u_shifter (
    .sck(sck),
    .chipSelectN(chipSelectN),
    .linkClear(linkClear),
    .mosi(mosi),
    .statusWord(statusWord),
    .txWord(txWord),
    .misoOut(misoOut),
    .rxByte(rxByte),
    .byteToggle(byteToggle)
  );

  assign misoEn = ~chipSelectN; // R23

  // ==========================================================
  // crossings from the link domain
  always_ff @(posedge clk) begin
    if (reset) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csPrev <= 1'b1;
      tglMeta <= 1'b0;
      tglSync <= 1'b0;
      tglSeen <= 1'b0;
      linkClear <= 1'b1;
    end else begin
      csMeta <= chipSelectN;
      csSync <= csMeta;
      csPrev <= csSync;
      tglMeta <= byteToggle;
      tglSync <= tglMeta;
      tglSeen <= tglSync;
      linkClear <= 1'b0;
    end
  end

  assign frameActive = ~csSync;
  assign frameStart = ~csSync & csPrev; // R5
  assign frameEnd = csSync & ~csPrev;
  assign byteEvent = (tglSync != tglSeen) & frameActive;
  assign cmdEvent = byteEvent & (state == ST_CMD);
  assign dataEvent = byteEvent & (state != ST_CMD);

  // ==========================================================
  // command decode
  always_comb begin
    cmdState = ST_IGNORE; // R22
    if (rxByte[7:5] == radio_spi_pkg::CMD_REG_READ_HI) begin
      cmdState = ST_REG_RD; // R9
    end else if (rxByte[7:5] == radio_spi_pkg::CMD_REG_WRITE_HI) begin
      cmdState = writeAllowed ? ST_REG_WR : ST_IGNORE; // R10
    end else if (rxByte == radio_spi_pkg::CMD_RX_READ) begin
      cmdState = ST_RX_RD; // R11
    end else if (rxByte == radio_spi_pkg::CMD_TX_WRITE) begin
      cmdState = ST_TX_WR; // R12
    end else if (rxByte == radio_spi_pkg::CMD_ACTIVATE) begin
      cmdState = writeAllowed ? ST_ACTIVATE : ST_IGNORE; // R16
    end else if (rxByte == radio_spi_pkg::CMD_WIDTH_READ) begin
      cmdState = ST_WIDTH; // R19
    end else if (rxByte[7:3] == radio_spi_pkg::CMD_ACK_WRITE_HI) begin
      if (featuresActive && receiveMode && rxByte[2:0] <= radio_spi_pkg::MAX_ACK_PIPE) begin
        cmdState = ST_TX_WR; // R20
      end
    end else if (rxByte == radio_spi_pkg::CMD_NOACK_WRITE) begin
      if (featuresActive && !receiveMode) begin
        cmdState = ST_TX_WR; // R21
      end
    end
  end

  // command state across one frame
  always_ff @(posedge clk) begin
    if (reset || frameStart || frameEnd) begin
      state <= ST_CMD;
    end else if (cmdEvent) begin
      state <= cmdState;
    end else if (dataEvent && (state == ST_ACTIVATE || state == ST_WIDTH)) begin
      state <= ST_IGNORE;
    end
  end

  // command attributes latched with the command byte
  always_ff @(posedge clk) begin
    if (reset) begin
      regAddr <= 5'h00;
      txNoAck <= 1'b0;
      txAckPayload <= 1'b0;
      txAckPipe <= 3'h0;
    end else if (cmdEvent) begin
      regAddr <= rxByte[4:0];
      txNoAck <= (rxByte == radio_spi_pkg::CMD_NOACK_WRITE); // R21
      txAckPayload <= (rxByte[7:3] == radio_spi_pkg::CMD_ACK_WRITE_HI); // R20
      txAckPipe <= rxByte[2:0];
    end
  end

  // byte counter, advanced one cycle after the data strobes
  always_ff @(posedge clk) begin
    if (reset) begin
      cmdTaken <= 1'b0;
      dataTaken <= 1'b0;
      loadTx <= 1'b0;
      cnt <= 6'h00;
    end else begin
      cmdTaken <= cmdEvent;
      dataTaken <= dataEvent;
      loadTx <= cmdTaken | dataTaken;
      if (cmdEvent) begin
        cnt <= 6'h00; // R11 R12
      end else if (dataTaken && cnt != 6'h3F) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // lane order: reversed for bank one registers 0 to 8
  assign reversed = regBank && (regAddr <= radio_spi_pkg::ADDR_REVERSED_LAST); // R8
  assign regLane = reversed ? (regByteCount - 3'h1 - cnt[2:0]) : cnt[2:0]; // R7 R8
  assign rxByteIndex = cnt[4:0];
  assign txByteIndex = cnt[4:0];

  // ==========================================================
  // write strobes for registers and payloads
  always_ff @(posedge clk) begin
    if (reset) begin
      regWrStrobe <= 1'b0;
      regWrData <= 8'h00;
      txPushStrobe <= 1'b0;
      txPushData <= 8'h00;
    end else begin
      regWrStrobe <= dataEvent && state == ST_REG_WR
                     && cnt < radio_spi_pkg::MAX_REG_BYTES; // R10
      txPushStrobe <= dataEvent && state == ST_TX_WR
                      && cnt < 6'(PAYLOAD_BYTES); // R12 R20 R21
      if (dataEvent) begin
        regWrData <= rxByte;
        txPushData <= rxByte;
      end
    end
  end

  // single cycle commands and frame end pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      flushTx <= 1'b0;
      flushRx <= 1'b0;
      rxPayloadDone <= 1'b0;
      txPayloadDone <= 1'b0;
    end else begin
      flushTx <= cmdEvent && rxByte == radio_spi_pkg::CMD_FLUSH_TX; // R13
      flushRx <= cmdEvent && rxByte == radio_spi_pkg::CMD_FLUSH_RX; // R14
      rxPayloadDone <= frameEnd && state == ST_RX_RD && cnt != 6'h00; // R11
      txPayloadDone <= frameEnd && state == ST_TX_WR && cnt != 6'h00;
    end
  end

  // payload repeat level
  always_ff @(posedge clk) begin
    if (reset) begin
      payloadRepeat <= 1'b0;
    end else if (cmdEvent) begin
      if (rxByte == radio_spi_pkg::CMD_REUSE) begin
        payloadRepeat <= 1'b1; // R15
      end else if (rxByte == radio_spi_pkg::CMD_TX_WRITE
                   || rxByte == radio_spi_pkg::CMD_FLUSH_TX) begin
        payloadRepeat <= 1'b0; // R15
      end
    end
  end

  // feature enable and bank toggles
  always_ff @(posedge clk) begin
    if (reset) begin
      featuresActive <= 1'b0; // R17
      regBank <= 1'b0;
    end else if (dataEvent && state == ST_ACTIVATE) begin
      if (rxByte == radio_spi_pkg::KEY_FEATURES) begin
        featuresActive <= ~featuresActive; // R16
      end
      if (rxByte == radio_spi_pkg::KEY_BANK) begin
        regBank <= ~regBank; // R18
      end
    end
  end

  // ==========================================================
  // byte returned on the next data byte
  always_ff @(posedge clk) begin
    if (reset || frameStart) begin
      txWord <= 8'h00;
    end else if (loadTx) begin
      unique case (state)
        ST_REG_RD: begin
          if (!regBank && regAddr == radio_spi_pkg::ADDR_STATUS && cnt == 6'h00) begin
            txWord <= statusNow; // R18
          end else begin
            txWord <= regRdData; // R9
          end
        end
        ST_RX_RD: txWord <= rxData; // R11
        ST_WIDTH: txWord <= featuresActive ? {2'h0, rxHeadWidth} : 8'h00; // R17 R19
        ST_CMD, ST_REG_WR, ST_TX_WR, ST_ACTIVATE, ST_IGNORE: txWord <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // interrupt flags, masks and pin
  assign clearMask = (regWrStrobe && !regBank && regAddr == radio_spi_pkg::ADDR_STATUS
                      && cnt == 6'h00)
                     ? {regWrData[radio_spi_pkg::BIT_RX_READY],
                        regWrData[radio_spi_pkg::BIT_TX_DONE],
                        regWrData[radio_spi_pkg::BIT_RETRY]} : 3'h0;

  // a set arriving with its clear wins
  assign next_flags = (flags & ~clearMask)
                      | {receiveReadySet, transmitDoneSet, retryLimitSet}; // R2
  assign next_irqN = ~|(next_flags & ~next_mask); // R1 R3

  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= 3'h0;
      irqN <= 1'b1;
    end else begin
      flags <= next_flags; // R2
      irqN <= next_irqN; // R1 R2
    end
  end

  // masks follow writes of configuration byte 0; pin uses the new mask at once
  assign next_mask = (regWrStrobe && !regBank && regAddr == radio_spi_pkg::ADDR_CONFIG
                      && cnt == 6'h00)
                     ? {regWrData[radio_spi_pkg::BIT_RX_READY],
                        regWrData[radio_spi_pkg::BIT_TX_DONE],
                        regWrData[radio_spi_pkg::BIT_RETRY]} : interruptMask; // R24

  always_ff @(posedge clk) begin
    if (reset) begin
      interruptMask <= radio_spi_pkg::MASK_RESET; // R3
    end else begin
      interruptMask <= next_mask; // R24
    end
  end

  // pipe field taken as the pin falls
  always_ff @(posedge clk) begin
    if (reset) begin
      pipeField <= radio_spi_pkg::PIPE_RESET;
    end else if (irqN && !next_irqN) begin
      pipeField <= pipeNumberIn; // R4
    end
  end

  // status byte, frozen for the link while a frame runs
  always_comb begin
    statusNow = 8'h00;
    statusNow[radio_spi_pkg::BIT_BANK] = regBank; // R18
    statusNow[radio_spi_pkg::BIT_RX_READY] = flags[2];
    statusNow[radio_spi_pkg::BIT_TX_DONE] = flags[1];
    statusNow[radio_spi_pkg::BIT_RETRY] = flags[0];
    statusNow[radio_spi_pkg::PIPE_LSB +: 3] = pipeField;
    statusNow[radio_spi_pkg::BIT_TX_FULL] = txFifoFull;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      statusWord <= 8'h00;
    end else if (!frameActive) begin
      statusWord <= statusNow; // R6 R22
    end
  end

  // ==========================================================
  // checks
  irq_assert_a: assert property (@(posedge clk) disable iff (reset) // R1
    (|(flags & ~interruptMask)) |-> !irqN)
    else $error("irq pin high with an unmasked flag set");

  irq_release_a: assert property (@(posedge clk) disable iff (reset) // R2
    (!irqN && clearMask == 3'h7 && !transmitDoneSet && !receiveReadySet
     && !retryLimitSet) |=> irqN)
    else $error("irq pin held after all flags cleared");

  set_wins_a: assert property (@(posedge clk) disable iff (reset) // R2
    (transmitDoneSet && clearMask[1]) |=> flags[1])
    else $error("flag set lost against a clear");

  mask_block_a: assert property (@(posedge clk) disable iff (reset) // R3
    (flags != 3'h0 && (flags & ~interruptMask) == 3'h0) |-> irqN)
    else $error("masked source drove the irq pin");

  pipe_hold_a: assert property (@(posedge clk) disable iff (reset) // R4
    !$fell(irqN) |-> $stable(pipeField))
    else $error("pipe field changed without irq falling edge");

  flush_tx_a: assert property (@(posedge clk) disable iff (reset) // R13
    (cmdEvent && rxByte == radio_spi_pkg::CMD_FLUSH_TX) |=> flushTx ##1 !flushTx)
    else $error("transmit flush not a single pulse");

  repeat_end_a: assert property (@(posedge clk) disable iff (reset) // R15
    flushTx |-> !payloadRepeat)
    else $error("payload repeat survived a transmit flush");

  locked_cmd_a: assert property (@(posedge clk) disable iff (reset) // R17
    (cmdEvent && !featuresActive && rxByte == radio_spi_pkg::CMD_NOACK_WRITE)
    |=> state == ST_IGNORE ##1 !txPushStrobe)
    else $error("disabled optional command was accepted");

  bank_toggle_a: assert property (@(posedge clk) disable iff (reset) // R18
    (dataEvent && state == ST_ACTIVATE && rxByte == radio_spi_pkg::KEY_BANK)
    |=> regBank != $past(regBank))
    else $error("bank did not toggle");

  write_gate_a: assert property (@(posedge clk) disable iff (reset) // R10
    (cmdEvent && !writeAllowed && rxByte[7:5] == radio_spi_pkg::CMD_REG_WRITE_HI)
    |=> !regWrStrobe [*3])
    else $error("register write outside standby");

endmodule // radio_spi_command_irq

// ### src/spi_link_shifter.sv
// package of shared constants and the serial shifter clocked by the link clock
package radio_spi_pkg;
  // command words and command prefixes
  localparam logic [2:0] CMD_REG_READ_HI = 3'h0;
  localparam logic [2:0] CMD_REG_WRITE_HI = 3'h1;
  localparam logic [7:0] CMD_RX_READ = 8'h61;
  localparam logic [7:0] CMD_WIDTH_READ = 8'h60;
  localparam logic [7:0] CMD_TX_WRITE = 8'hA0;
  localparam logic [4:0] CMD_ACK_WRITE_HI = 5'h15;
  localparam logic [7:0] CMD_NOACK_WRITE = 8'hB0;
  localparam logic [7:0] CMD_FLUSH_TX = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX = 8'hE2;
  localparam logic [7:0] CMD_REUSE = 8'hE3;
  localparam logic [7:0] CMD_ACTIVATE = 8'h50;
  localparam logic [7:0] CMD_NOP = 8'hFF;
  // data keys that follow the activate command
  localparam logic [7:0] KEY_FEATURES = 8'h73;
  localparam logic [7:0] KEY_BANK = 8'h53;
  // register addresses and limits
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  localparam logic [4:0] ADDR_REVERSED_LAST = 5'h08;
  localparam logic [5:0] MAX_REG_BYTES = 6'h05;
  localparam int MAX_PAYLOAD_BYTES = 32;
  localparam logic [2:0] MAX_ACK_PIPE = 3'h5;
  // field positions in the configuration and status bytes
  localparam int BIT_BANK = 7;
  localparam int BIT_RX_READY = 6;
  localparam int BIT_TX_DONE = 5;
  localparam int BIT_RETRY = 4;
  localparam int PIPE_LSB = 1;
  localparam int BIT_TX_FULL = 0;
  // reset values
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [2:0] PIPE_RESET = 3'h7;
endpackage

`timescale 1ns/100ps

module spi_link_shifter (
  input wire logic sck, // link clock from the host
  input wire logic chipSelectN, // frame select, low during a frame
  input wire logic linkClear, // clears the byte handover state
  input wire logic mosi, // serial data in
  input wire logic [7:0] statusWord, // status byte shifted during the command
  input wire logic [7:0] txWord, // byte to shift out next
  output logic misoOut, // serial data out
  output logic [7:0] rxByte, // last whole byte received
  output logic byteToggle // flips once per received byte
);

  logic [2:0] bitCnt;
  logic [6:0] rxShift;
  logic [7:0] txShift;
  logic started;

  // ==========================================================
  // receive side, sampled on the rising edge
  always_ff @(posedge sck or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitCnt <= 3'h0;
      rxShift <= 7'h00;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      rxShift <= {rxShift[5:0], mosi};
    end
  end

  // byte handover outlives the frame so the fast side can still read it
  always_ff @(posedge sck or posedge linkClear) begin
    if (linkClear) begin
      rxByte <= 8'h00;
      byteToggle <= 1'b0;
    end else if (bitCnt == 3'h7) begin
      rxByte <= {rxShift, mosi};
      byteToggle <= ~byteToggle;
    end
  end

  // ==========================================================
  // transmit side, changed on the falling edge
  always_ff @(negedge sck or posedge chipSelectN) begin
    if (chipSelectN) begin
      txShift <= 8'h00;
      started <= 1'b0;
    end else if (!started) begin
      txShift <= {statusWord[6:0], 1'b0};
      started <= 1'b1;
    end else if (bitCnt == 3'h0) begin
      txShift <= txWord;
    end else begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  // first bit must stand before any clock edge of the frame
  assign misoOut = started ? txShift[7] : statusWord[7];

endmodule // spi_link_shifter

// ### sim/spi_host_model.sv
// host side serial master model for the control port
`timescale 1ns/100ps
module spi_host_model (
  output logic sck, // link clock, still outside frames
  output logic chipSelectN, // frame select
  output logic mosi, // serial data out
  input wire logic miso, // resolved data pin
  output logic [7:0] gotByte, // last byte read back
  output logic gotToggle // flips per byte read
);
  initial begin
    sck = 1'b0;
    chipSelectN = 1'b1;
    mosi = 1'b0;
    gotByte = 8'h00;
    gotToggle = 1'b0;
  end
  // one frame, byte 0 in the low bits, each byte read back
  task automatic frame(input logic [39:0] b, input int n);
    int i;
    int k;
    logic [7:0] r;
    chipSelectN = 1'b0;
    #20;
    for (i = 0; i < n; i++) begin
      for (k = 7; k >= 0; k--) begin
        mosi = b[8*i+k];
        #3 sck = 1'b1;
        r[k] = miso;
        if (k > 0) #3 sck = 1'b0;
      end
      gotByte = r;
      gotToggle = ~gotToggle;
      #400 sck = 1'b0; // pacing so the reply is loaded
    end
    mosi = ~mosi; // no stale level after release
    #20 chipSelectN = 1'b1;
    #200;
  endtask
endmodule // spi_host_model

// ### sim/tb.sv
// self-checking bench for the radio control port
`timescale 1ns/100ps
module tb;
  logic clk, reset, sck, chipSelectN, mosi, misoOut, misoEn, irqN, hostTog;
  logic doneSet, readySet, retrySet, txFull, wrOk, rxMode, bank;
  logic [2:0] pipe, pipeExp, lane, regCount, mask;
  logic [4:0] rxIdx, txIdx;
  logic [5:0] headWidth;
  logic [7:0] seed, hostByte, pushData;
  logic push, fTx, fRx, rxDone, txDone, noAck, ackPay, rep, feat;
  logic [2:0] ackPipe;
  int errors, comparisons, cnt[4];
  logic [15:0] expq[$];
  logic [7:0] txq[$];
  wire misoPin = misoEn ? misoOut : 1'bz;
  // partner drives the link
  spi_host_model u_host (.sck(sck), .chipSelectN(chipSelectN), .mosi(mosi),
    .miso(misoPin), .gotByte(hostByte), .gotToggle(hostTog));
  radio_spi_command_irq u_dut (.clk(clk), .reset(reset), .sck(sck),
    .chipSelectN(chipSelectN), .mosi(mosi), .misoOut(misoOut), .misoEn(misoEn),
    .irqN(irqN), .transmitDoneSet(doneSet), .receiveReadySet(readySet),
    .retryLimitSet(retrySet), .pipeNumberIn(pipe), .txFifoFull(txFull),
    .writeAllowed(wrOk), .receiveMode(rxMode), .regAddr(), .regBank(),
    .regLane(lane), .regByteCount(regCount), .regRdData({5'h01, lane} ^ seed),
    .regWrStrobe(), .regWrData(), .rxByteIndex(rxIdx), .rxData({3'h5, rxIdx} ^ seed),
    .rxHeadWidth(headWidth), .rxPayloadDone(rxDone), .txPushStrobe(push),
    .txPushData(pushData), .txByteIndex(txIdx), .txNoAck(noAck),
    .txAckPayload(ackPay), .txAckPipe(ackPipe), .txPayloadDone(txDone),
    .flushTx(fTx), .flushRx(fRx), .payloadRepeat(rep), .featuresActive(feat),
    .interruptMask(mask));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // queue expected reply bytes (value, mask) then run the frame
  task automatic send(input logic [39:0] b, input int n, input logic [39:0] e,
                      input logic [39:0] m);
    for (int i = 0; i < n; i++) expq.push_back({e[8*i+:8], m[8*i+:8]});
    u_host.frame(b, n);
    @(negedge clk);
  endtask
  function automatic logic [7:0] st(input logic [2:0] f);
    return {bank, f, pipeExp, txFull};
  endfunction
  task automatic pulse(input int s);
    @(negedge clk);
    {readySet, doneSet, retrySet} = 3'h4 >> s;
    @(negedge clk);
    {readySet, doneSet, retrySet} = 3'h0;
    repeat (3) @(negedge clk);
  endtask
  // reply bytes and payload pushes are compared as they appear
  always @(hostTog) begin
    logic [15:0] x;
    if (expq.size() == 0) x = 16'h0000;
    else x = expq.pop_front();
    check(hostByte & x[7:0], x[15:8] & x[7:0]);
  end
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + int'(fTx);
    cnt[1] <= cnt[1] + int'(fRx);
    cnt[2] <= cnt[2] + int'(rxDone);
    cnt[3] <= cnt[3] + int'(txDone);
    if (push) check(pushData, (txq.size() > 0) ? txq.pop_front() : 8'hXX);
  end
  initial begin
    int w;
    cnt = '{0, 0, 0, 0};
    {reset, doneSet, readySet, retrySet, wrOk, rxMode, bank} = 7'h44;
    {pipe, pipeExp, regCount, headWidth} = {3'h0, 3'h7, 3'h3, 6'h01};
    void'($urandom(44398));
    seed = 8'($urandom);
    txFull = 1'($urandom);
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    check({irqN, feat, 3'h0, mask}, 8'h80);
    send(40'hFF, 1, st(3'h0), 40'hFF);
    // receive-ready pulls the pin low and latches the pipe
    pipe = 3'($urandom % 6);
    pulse(0);
    pipeExp = pipe;
    check({7'h0, irqN}, 8'h00);
    send(40'hFF, 1, st(3'h4), 40'hFF);
    send(40'h70_27, 2, st(3'h4), 40'h00FF);
    repeat (3) @(negedge clk);
    check({7'h0, irqN}, 8'h01);
    $display("test irq done");
    // masked sources keep the pin released
    send(40'h70_20, 2, 0, 0);
    check({5'h0, mask}, 8'h07);
    for (w = 0; w < 3; w++) pulse(w);
    check({7'h0, irqN}, 8'h01);
    wrOk = 1'b0;
    send(40'h00_20, 2, 0, 0);
    check({5'h0, mask}, 8'h07);
    wrOk = 1'b1;
    send(40'h00_20, 2, 0, 0);
    check({7'h0, irqN}, 8'h00);
    send(40'h70_27, 2, st(3'h7), 40'h00FF);
    check({7'h0, irqN}, 8'h01);
    $display("test mask done");
    // byte order in both banks
    send(40'h00_00_00_02, 4, {8'h0A ^ seed, 8'h09 ^ seed, 8'h08 ^ seed, st(0)}, 40'hFFFFFFFF);
    send(40'h53_50, 2, 0, 0);
    bank = 1'b1;
    send(40'h00_00_00_02, 4, {8'h08 ^ seed, 8'h09 ^ seed, 8'h0A ^ seed, st(0)}, 40'hFFFFFFFF);
    send(40'h53_50, 2, 0, 0);
    bank = 1'b0;
    $display("test bank done");
    // flushes, repeat and payload write
    send(40'hE3, 1, 0, 0);
    check({7'h0, rep}, 8'h01);
    send(40'hE1, 1, 0, 0);
    check({7'h0, rep}, 8'h00);
    send(40'hE2, 1, 0, 0);
    send(40'hE3, 1, 0, 0);
    check({7'h0, rep}, 8'h01);
    txq.push_back(seed);
    txq.push_back(~seed);
    send({16'h0, ~seed, seed, 8'hA0}, 3, 0, 0);
    repeat (8) @(negedge clk);
    check({7'h0, rep}, 8'h00);
    check({5'h0, cnt[0][0], cnt[1][0], cnt[3][0]}, 8'h07);
    $display("test fifo done");
    // optional commands: off, then on
    headWidth = 6'($urandom % 32 + 1);
    send(40'h00_B0, 2, 0, 0);
    send(40'h00_60, 2, 0, 40'hFF00);
    send(40'h73_50, 2, 0, 0);
    check({7'h0, feat}, 8'h01);
    send(40'h00_60, 2, {2'h0, headWidth, 8'h00}, 40'hFF00);
    rxMode = 1'b1;
    txq.push_back(8'h5A);
    send(40'h5A_A9, 2, 0, 0);
    check({ackPay, 4'h0, ackPipe}, 8'h81);
    rxMode = 1'b0;
    txq.push_back(8'hC3);
    send(40'hC3_B0, 2, 0, 0);
    check({7'h0, noAck}, 8'h01);
    send(40'h00_00_61, 3, {8'hA1 ^ seed, 8'hA0 ^ seed, 8'h00}, 40'hFFFF00);
    repeat (8) @(negedge clk);
    check(8'(cnt[2]), 8'h01);
    $display("test optional done");
    results();
  end
  initial begin
    #2000000;
    errors++;
    results();
  end
endmodule // tb
